// ===== bds_fault_reg.sv
`timescale 1ns/1ps
module bds_fault_reg (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       clear_in,
    input  wire logic       undervoltage_in,
    input  wire logic       shorted_load_in,
    input  wire logic       out1_short_supply_in,
    input  wire logic       out1_short_ground_in,
    input  wire logic       out2_short_supply_in,
    input  wire logic       out2_short_ground_in,
    input  wire logic       open_load_in,
    input  wire logic       overcurrent_in,
    input  wire logic       cutback_in,
    input  wire logic       over_heat_in,
    output logic [3:0]      status_code_out,
    output logic            low_side_overcurrent_flag_out,
    output logic            thermal_cutback_flag_out,
    output logic            over_heat_flag_out,
    output logic            any_fault_out
);
    import bds_pkg::*;

    logic [3:0] code_r;
    logic [3:0] code_nxt;
    logic [3:0] event_code;
    logic       event_seen;
    logic [1:0] pair1;
    logic [1:0] pair2;

    // smaller number wins; the latched power-on code outranks every fault
    function automatic logic [2:0] prio(input logic [3:0] c);
        if (c == CODE_ZERO)
            prio = 3'h1;
        else if (c == CODE_SHORTED)
            prio = 3'h2;
        else if (c == CODE_OPEN)
            prio = 3'h4;
        else if (c == CODE_NORMAL)
            prio = 3'h5;
        else
            prio = 3'h3;
    endfunction

    always_comb
    begin
        pair1      = out1_short_supply_in ? PAIR_TO_SUPPLY : (out1_short_ground_in ? PAIR_TO_GROUND : PAIR_NORMAL);
        pair2      = out2_short_supply_in ? PAIR_TO_SUPPLY : (out2_short_ground_in ? PAIR_TO_GROUND : PAIR_NORMAL);
        event_seen = 1'b1;
        if (shorted_load_in)
            event_code = CODE_SHORTED;
        else if (pair1 != PAIR_NORMAL || pair2 != PAIR_NORMAL)
            event_code = {pair2, pair1};
        else if (open_load_in)
            event_code = CODE_OPEN;
        else
        begin
            event_code = CODE_NORMAL;
            event_seen = 1'b0;
        end
    end

    // a fault arriving with the clear is applied on top of the cleared value
    always_comb
    begin
        code_nxt = clear_in ? CODE_NORMAL : code_r;
        if (event_seen && prio(event_code) < prio(code_nxt))
            code_nxt = event_code;
        else if (event_seen && prio(event_code) == 3'h3 && prio(code_nxt) == 3'h3)
        begin
            if (event_code[3:2] != PAIR_NORMAL)
                code_nxt[3:2] = event_code[3:2];
            if (event_code[1:0] != PAIR_NORMAL)
                code_nxt[1:0] = event_code[1:0];
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            code_r <= CODE_ZERO;
        else
            code_r <= code_nxt;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            low_side_overcurrent_flag_out <= FLAG_RESET;
            thermal_cutback_flag_out      <= FLAG_RESET;
            over_heat_flag_out            <= FLAG_RESET;
        end
        else
        begin
            low_side_overcurrent_flag_out <= ~overcurrent_in & (clear_in | low_side_overcurrent_flag_out);
            thermal_cutback_flag_out      <= ~cutback_in & (clear_in | thermal_cutback_flag_out);
            over_heat_flag_out            <= ~over_heat_in & (clear_in | over_heat_flag_out);
        end
    end

    // undervoltage masks the stored code without touching it, so it returns afterwards
    assign status_code_out = undervoltage_in ? CODE_ZERO : code_r;
    assign any_fault_out   = (status_code_out != CODE_NORMAL) | ~low_side_overcurrent_flag_out
                             | ~thermal_cutback_flag_out | ~over_heat_flag_out;
endmodule

// ===== bds_host_model.sv
`timescale 1ns/1ps
module bds_host_model (
    output logic      spi_sclk_out,
    output logic      select_n_out,
    output logic      spi_si_out,
    input  wire logic spi_so_in,
    input  wire logic spi_so_oe_in
);
    initial
    begin
        spi_sclk_out = 1'b0;
        select_n_out = 1'b1;
        spi_si_out   = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // si moves 100 ns after a fall so it never races the synchronised clock edge
    task automatic frame(input logic [15:0] tx, input int nclk, output logic [15:0] rx);
        rx = 'z;
        select_n_out = 1'b0;
        spi_si_out = tx[15];
        #400;
        for (int i = 0; i < nclk; i++)
        begin
            spi_sclk_out = 1'b1;
            #400 spi_sclk_out = 1'b0;
            rx[15-i] = spi_so_oe_in ? spi_so_in : 1'bz;
            #100 spi_si_out = (i < 15) ? tx[14-i] : ~spi_si_out;
            #300;
        end
        select_n_out = 1'b1;
        spi_si_out = ~spi_si_out;
        #800;
    endtask
endmodule

// ===== bds_pkg.sv
package bds_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // frame layout
    localparam int FRAME_BITS      = 16;
    localparam int ID_BITS         = 2;
    localparam int CMD_BITS        = 8;
    localparam int FIRST_DRIVEN    = 13;
    localparam logic [1:0] CHIP_ADDR       = 2'h0;
    localparam logic [4:0] VERIFY_PATTERN  = 5'h15;

    ////////////////////////////////////////////////////////////////////////////
    // command bytes, chip address bits included
    localparam logic [7:0] CMD_WRITE_SETUP = 8'h33;
    localparam logic [7:0] CMD_READ_CLEAR  = 8'h09;
    localparam logic [7:0] CMD_READ_ID     = 8'h00;
    localparam logic [7:0] CMD_READ_REV    = 8'h03;
    localparam logic [7:0] CMD_READ_SETUP  = 8'h28;

    ////////////////////////////////////////////////////////////////////////////
    // drive_setup: bits 7:2 of the written byte are stored as a 6-bit field
    localparam int SETUP_ROLE_POS  = 5;
    localparam int SETUP_PUMP_POS  = 4;
    localparam int SETUP_OUT2_POS  = 3;
    localparam int SETUP_OUT1_POS  = 2;
    localparam int SETUP_LIM_HI    = 1;
    localparam int SETUP_LIM_LO    = 0;
    localparam logic [5:0] SETUP_RESET     = 6'h0e;

    // limit selector codes
    localparam logic [1:0] LIMIT_LEVEL_4   = 2'h3;
    localparam logic [1:0] LIMIT_LEVEL_3   = 2'h2;
    localparam logic [1:0] LIMIT_LEVEL_2   = 2'h1;
    localparam logic [1:0] LIMIT_LEVEL_1   = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // fault status codes {out2_status_hi, out2_status_lo, out1_status_hi, out1_status_lo}
    localparam logic [3:0] CODE_ZERO      = 4'h0;
    localparam logic [3:0] CODE_SHORTED   = 4'hc;
    localparam logic [3:0] CODE_OPEN      = 4'h3;
    localparam logic [3:0] CODE_NORMAL    = 4'hf;
    localparam logic [1:0] PAIR_TO_SUPPLY = 2'h1;
    localparam logic [1:0] PAIR_TO_GROUND = 2'h2;
    localparam logic [1:0] PAIR_NORMAL    = 2'h3;
    localparam logic       FLAG_RESET     = 1'b1;

    // identity values: arbitrary
    localparam logic [7:0] PART_IDENTITY  = 8'h5a;
    localparam logic [3:0] FW_REVISION    = 4'h2;
    localparam logic [3:0] MASK_REVISION  = 4'h7;

endpackage

// ===== bds_spi_core.sv
`timescale 1ns/1ps
// Functional notes
// - write-setup 0x33 loads setup from data 7:2, answers fault report, no clear
// - setup changes only while enable pin is low; host keeps it low to write
// - read-and-clear 0x09 returns fault report then clears all latched faults
// - setup bits 3:2 pick limit: 11 level4, 10 level3 default, 01 level2, 00 level1
// - setup bits 5,4 allow outputs 2,1; status bit 7 shows live enable
// - setup bit 7 sets fault pin role; bit 6 sets reduced pump power
// - response bits 3:0 carry latched two-output status codes
// - stored code priority: power-on 0000, shorted load, shorts, open load
// - undervoltage shows 0000 unlatched; prior code returns afterwards
// - clear by pins or command drops all latched faults including overwritten
// - power-on reset latches status code 0000
// - response bit 4 latches 0 after low-side overcurrent
// - bits 5 and 6 latch 0 after thermal cutback and over-heat
// - response bit 8 is the latched frame fault flag
// - response bits 13:9 always carry 10101 for a matching address
// - read-identity 0x00 returns fixed identity byte
// - read-revision 0x03 returns firmware and mask revisions
// - read-setup 0x28 returns role, pump, both-outputs, lockout, limit, over-heat and cutback bits
// - top two bits must be 00 else frame ignored, output stays off
// - commit at select rise only after exactly 16 clocks and valid command
// - input sampled on falling clock, output changes on rising, msb first
// - next valid frame clears frame fault; bad frames leave registers alone
module bds_spi_core (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       spi_sclk_in,
    input  wire logic       select_n_in,
    input  wire logic       spi_si_in,
    output logic            spi_so_out,
    output logic            spi_so_oe_out,
    input  wire logic       enable_pin_in,
    input  wire logic       disable_or_fault_pin_in,
    output logic            disable_or_fault_pin_out,
    output logic            disable_or_fault_pin_oe_out,
    input  wire logic       lockout_in,
    input  wire logic       undervoltage_in,
    input  wire logic       shorted_load_in,
    input  wire logic       out1_short_supply_in,
    input  wire logic       out1_short_ground_in,
    input  wire logic       out2_short_supply_in,
    input  wire logic       out2_short_ground_in,
    input  wire logic       open_load_in,
    input  wire logic       overcurrent_in,
    input  wire logic       cutback_in,
    input  wire logic       over_heat_in,
    output logic            out1_enable_out,
    output logic            out2_enable_out,
    output logic [1:0]      limit_level_out,
    output logic            pump_power_reduced_out,
    output logic            fault_pin_role_out
);
    import bds_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; the reset image equals the edge detectors' reset levels, so no false edge follows reset
    logic [4:0] pins_sync;
    logic       sclk_s;
    logic       sel_n_s;
    logic       si_s;
    logic       en_pin_s;
    logic       dis_pin_s;

    bds_sync #(
        .WIDTH (5),
        .INIT  (5'h08)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .async_in   ({spi_sclk_in, select_n_in, spi_si_in, enable_pin_in, disable_or_fault_pin_in}),
        .sync_out   (pins_sync)
    );

    assign sclk_s    = pins_sync[4];
    assign sel_n_s   = pins_sync[3];
    assign si_s      = pins_sync[2];
    assign en_pin_s  = pins_sync[1];
    assign dis_pin_s = pins_sync[0];

    ////////////////////////////////////////////////////////////////////////////
    // edge detection on the synchronised levels
    logic sclk_d_r;
    logic sel_n_d_r;
    logic en_pin_d_r;
    logic dis_pin_d_r;

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            sclk_d_r    <= 1'b0;
            sel_n_d_r   <= 1'b1;
            en_pin_d_r  <= 1'b0;
            dis_pin_d_r <= 1'b0;
        end
        else
        begin
            sclk_d_r    <= sclk_s;
            sel_n_d_r   <= sel_n_s;
            en_pin_d_r  <= en_pin_s;
            dis_pin_d_r <= dis_pin_s;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic frame_end;
    logic in_frame;

    assign in_frame    = ~sel_n_s & ~sel_n_d_r;
    assign sclk_rise   = in_frame & sclk_s & ~sclk_d_r;
    assign sclk_fall   = in_frame & ~sclk_s & sclk_d_r;
    assign frame_start = ~sel_n_s & sel_n_d_r;
    assign frame_end   = sel_n_s & ~sel_n_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // receive side: falling edges shift in, msb first
    logic [4:0]  fall_cnt_r;
    logic [15:0] rx_r;
    logic        id_ok_r;
    logic [7:0]  cmd_r;
    logic        cmd_valid;
    logic [7:0]  cmd_now;

    assign cmd_now   = {rx_r[6:0], si_s};
    assign cmd_valid = (cmd_r == CMD_WRITE_SETUP) || (cmd_r == CMD_READ_CLEAR) || (cmd_r == CMD_READ_ID)
                       || (cmd_r == CMD_READ_REV) || (cmd_r == CMD_READ_SETUP);

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in || frame_start)
        begin
            fall_cnt_r <= 5'h00;
            rx_r       <= 16'h0000;
            id_ok_r    <= 1'b0;
            cmd_r      <= 8'hff;
        end
        else if (sclk_fall)
        begin
            rx_r <= {rx_r[14:0], si_s};
            if (fall_cnt_r != 5'h1f)
                fall_cnt_r <= fall_cnt_r + 5'h01;
            if (fall_cnt_r == 5'(ID_BITS - 1))
                id_ok_r <= ({rx_r[0], si_s} == CHIP_ADDR);
            if (fall_cnt_r == 5'(CMD_BITS - 1))
                cmd_r <= cmd_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // setup register and live enable state
    logic [5:0] setup_r;
    logic       pins_enable;
    logic       enable_status;
    logic       do_commit;

    // the pin counts as a disable input only while it plays that role
    assign pins_enable   = en_pin_s & (setup_r[SETUP_ROLE_POS] | ~dis_pin_s);
    assign enable_status = pins_enable & setup_r[SETUP_OUT1_POS] & setup_r[SETUP_OUT2_POS] & ~lockout_in;
    assign do_commit     = frame_end & id_ok_r & (fall_cnt_r == 5'(FRAME_BITS)) & cmd_valid;

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            setup_r <= SETUP_RESET;
        else if (do_commit && cmd_r == CMD_WRITE_SETUP && !en_pin_s)
            setup_r <= rx_r[7:2];
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame fault flag: only frames with our address touch it
    logic frame_fault_r;

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            frame_fault_r <= 1'b0;
        else if (frame_end && id_ok_r)
            frame_fault_r <= ~do_commit;
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault report
    logic       spi_clear;
    logic       pin_clear;
    logic [3:0] status_code;
    logic       oc_flag;
    logic       cutback_flag;
    logic       heat_flag;
    logic       any_fault;

    assign spi_clear = do_commit & (cmd_r == CMD_READ_CLEAR);
    // in the disable-pin role (setup bit 7 low), re-enable through either pin also discards the report
    assign pin_clear = (en_pin_s & ~en_pin_d_r & ~dis_pin_s & ~setup_r[SETUP_ROLE_POS])
                       | (~dis_pin_s & dis_pin_d_r & en_pin_s & ~setup_r[SETUP_ROLE_POS]);

    bds_fault_reg u_faults (
        .sys_clk_in                    (sys_clk_in),
        .rst_in                        (rst_in),
        .clear_in                      (spi_clear | pin_clear),
        .undervoltage_in               (undervoltage_in),
        .shorted_load_in               (shorted_load_in),
        .out1_short_supply_in          (out1_short_supply_in),
        .out1_short_ground_in          (out1_short_ground_in),
        .out2_short_supply_in          (out2_short_supply_in),
        .out2_short_ground_in          (out2_short_ground_in),
        .open_load_in                  (open_load_in),
        .overcurrent_in                (overcurrent_in),
        .cutback_in                    (cutback_in),
        .over_heat_in                  (over_heat_in),
        .status_code_out               (status_code),
        .low_side_overcurrent_flag_out (oc_flag),
        .thermal_cutback_flag_out      (cutback_flag),
        .over_heat_flag_out            (heat_flag),
        .any_fault_out                 (any_fault)
    );

    ////////////////////////////////////////////////////////////////////////////
    // response byte, captured once the command is known
    logic [7:0] data_r;
    logic [7:0] data_nxt;

    always_comb
    begin
        unique case (cmd_now)
            CMD_WRITE_SETUP,
            CMD_READ_CLEAR:
                data_nxt = {enable_status, heat_flag, cutback_flag, oc_flag, status_code};
            CMD_READ_ID:
                data_nxt = PART_IDENTITY;
            CMD_READ_REV:
                data_nxt = {FW_REVISION, MASK_REVISION};
            CMD_READ_SETUP:
                data_nxt = {setup_r[SETUP_ROLE_POS], setup_r[SETUP_PUMP_POS],
                            setup_r[SETUP_OUT1_POS] & setup_r[SETUP_OUT2_POS], lockout_in,
                            setup_r[SETUP_LIM_HI], setup_r[SETUP_LIM_LO], heat_flag, cutback_flag};
            default:
                data_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            data_r <= 8'h00;
        else if (sclk_fall && fall_cnt_r == 5'(CMD_BITS - 1))
            data_r <= data_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit side: rising edge k drives bit 16-k
    logic [15:0] resp_word;
    logic [4:0]  tx_idx;

    assign resp_word = {2'h0, VERIFY_PATTERN, frame_fault_r, data_r};
    assign tx_idx    = 5'(FRAME_BITS - 1) - fall_cnt_r;

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in || frame_start || frame_end)
        begin
            spi_so_out    <= 1'b0;
            spi_so_oe_out <= 1'b0;
        end
        else if (sclk_rise && id_ok_r && fall_cnt_r >= 5'(ID_BITS) && fall_cnt_r < 5'(FRAME_BITS))
        begin
            spi_so_out    <= resp_word[tx_idx[3:0]];
            spi_so_oe_out <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // setup-driven outputs
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            out1_enable_out             <= 1'b0;
            out2_enable_out             <= 1'b0;
            limit_level_out             <= LIMIT_LEVEL_3;
            pump_power_reduced_out      <= 1'b0;
            fault_pin_role_out          <= 1'b0;
            disable_or_fault_pin_out    <= 1'b0;
            disable_or_fault_pin_oe_out <= 1'b0;
        end
        else
        begin
            out1_enable_out             <= pins_enable & setup_r[SETUP_OUT1_POS] & ~lockout_in;
            out2_enable_out             <= pins_enable & setup_r[SETUP_OUT2_POS] & ~lockout_in;
            limit_level_out             <= {setup_r[SETUP_LIM_HI], setup_r[SETUP_LIM_LO]};
            pump_power_reduced_out      <= setup_r[SETUP_PUMP_POS];
            fault_pin_role_out          <= setup_r[SETUP_ROLE_POS];
            // status flag role: pin is pulled low while any fault is held
            disable_or_fault_pin_out    <= ~any_fault;
            disable_or_fault_pin_oe_out <= setup_r[SETUP_ROLE_POS];
        end
    end
endmodule

// ===== bds_spi_core_checker.sv
`timescale 1ns/1ps
module bds_spi_core_checker (
    input wire logic       sys_clk_in,
    input wire logic       rst_in,
    input wire logic       spi_sclk_in,
    input wire logic       select_n_in,
    input wire logic       spi_so_out,
    input wire logic       spi_so_oe_out,
    input wire logic       enable_pin_in,
    input wire logic       lockout_in,
    input wire logic       out1_enable_out,
    input wire logic       out2_enable_out,
    input wire logic [1:0] limit_level_out,
    input wire logic       pump_power_reduced_out,
    input wire logic       fault_pin_role_out,
    input wire logic       disable_or_fault_pin_oe_out
);
    import bds_pkg::*;
    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_deselected;
        select_n_in [*8];
    endsequence
    sequence s_clock_low;
        (!select_n_in && !spi_sclk_in) [*5];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_so_released: assert property (s_deselected |-> !spi_so_oe_out)
        else $error("serial output driven while deselected");
    a_oe_in_frame: assert property ($rose(spi_so_oe_out) |-> !select_n_in)
        else $error("serial output enabled outside a frame");
    a_reset_setup: assert property ($fell(rst_in) |-> limit_level_out == LIMIT_LEVEL_3
        && !pump_power_reduced_out && !fault_pin_role_out && !spi_so_oe_out)
        else $error("setup outputs not at reset values");
    a_setup_frozen: assert property (enable_pin_in [*6] |-> $stable(limit_level_out)
        && $stable(pump_power_reduced_out) && $stable(fault_pin_role_out))
        else $error("setup changed while enable pin high");
    a_outs_need_pin: assert property ((!enable_pin_in) [*5] |-> !out1_enable_out && !out2_enable_out)
        else $error("output enabled with enable pin low");
    a_lockout_blocks: assert property (lockout_in |=> !out1_enable_out && !out2_enable_out)
        else $error("output enabled during lockout");
    a_pin_role: assert property (disable_or_fault_pin_oe_out == fault_pin_role_out)
        else $error("fault pin drive does not follow role");
    a_so_steady: assert property (s_clock_low ##0 spi_so_oe_out |-> $stable(spi_so_out))
        else $error("serial output changed while clock low");
endmodule

// ===== bds_spi_core_tb.sv
`timescale 1ns/1ps
module bds_spi_core_tb;
    import bds_pkg::*;
    logic        clk, rst, en, dis, lock, uv;
    logic [8:0]  flt;
    logic [15:0] rx;
    wire         sclk, sel_n, si, so, so_oe, o1, o2, pump, role, pin_oe, pin_o;
    wire [1:0]   lim;
    int          n_fail = 0;
    int          n_checks = 0;

    bds_host_model host (.spi_sclk_out(sclk), .select_n_out(sel_n), .spi_si_out(si),
        .spi_so_in(so), .spi_so_oe_in(so_oe));
    bds_spi_core DUT (.sys_clk_in(clk), .rst_in(rst), .spi_sclk_in(sclk), .select_n_in(sel_n),
        .spi_si_in(si), .spi_so_out(so), .spi_so_oe_out(so_oe), .enable_pin_in(en),
        .disable_or_fault_pin_in(dis), .disable_or_fault_pin_out(pin_o), .disable_or_fault_pin_oe_out(pin_oe),
        .lockout_in(lock), .undervoltage_in(uv), .shorted_load_in(flt[8]), .out1_short_supply_in(flt[7]),
        .out1_short_ground_in(flt[6]), .out2_short_supply_in(flt[5]), .out2_short_ground_in(flt[4]),
        .open_load_in(flt[3]), .overcurrent_in(flt[2]), .cutback_in(flt[1]), .over_heat_in(flt[0]),
        .out1_enable_out(o1), .out2_enable_out(o2), .limit_level_out(lim),
        .pump_power_reduced_out(pump), .fault_pin_role_out(role));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task finish_test;
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task w;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task xfer(input logic [15:0] tx, input int n);
        @(posedge clk);
        #1;
        host.frame(tx, n, rx);
    endtask
    task rsp(input logic [15:0] tx, input logic ferr, input logic [7:0] exp);
        xfer(tx, 16);
        chk(rx, {2'bzz, VERIFY_PATTERN, ferr, exp});
    endtask
    task ev(input logic [8:0] m);
        @(posedge clk);
        #1 flt = m;
        @(posedge clk);
        #1 flt = '0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        chk(16'({lim, pump, role, pin_oe, pin_o}), 16'h0020);
        rsp(16'h2800, 1'b0, 8'h2b);
        rsp(16'h0900, 1'b0, 8'h70);
        rsp(16'h0900, 1'b0, 8'h7f);
        rsp(16'h00ff, 1'b0, PART_IDENTITY);
        rsp(16'h03aa, 1'b0, {FW_REVISION, MASK_REVISION});
    endtask
    task t_setup;
        for (int k = 0; k < 4; k++)
        begin
            rsp({8'h33, 4'h3, 2'(k), 2'h3}, 1'b0, 8'h7f);
            chk(16'(lim), 16'(k));
            rsp(16'h2800, 1'b0, {4'h2, 2'(k), 2'h3});
        end
        rsp(16'h33c3, 1'b0, 8'h7f);
        chk(16'({lim, pump, role, pin_oe, pin_o}), 16'h000f);
        en = 1'b1;
        rsp(16'h3338, 1'b0, 8'h7f);
        rsp(16'h2800, 1'b0, 8'hc3);
        en = 1'b0;
        rsp(16'h3338, 1'b0, 8'h7f);
    endtask
    task t_faults;
        ev(9'h008);
        rsp(16'h3338, 1'b0, 8'h73);
        chk(16'(pin_o), 16'h0000);
        ev(9'h0a4);
        rsp(16'h3338, 1'b0, 8'h65);
        uv = 1'b1;
        rsp(16'h3338, 1'b0, 8'h60);
        uv = 1'b0;
        rsp(16'h3338, 1'b0, 8'h65);
        ev(9'h103);
        rsp(16'h0900, 1'b0, 8'h0c);
        rsp(16'h0900, 1'b0, 8'h7f);
        chk(16'(pin_o), 16'h0001);
    endtask
    task t_errors;
        xfer(16'h1100, 16);
        rsp(16'h2800, 1'b1, 8'h2b);
        rsp(16'h2800, 1'b0, 8'h2b);
        xfer(16'h33c0, 15);
        rsp(16'h2800, 1'b1, 8'h2b);
        xfer(16'h6800, 16);
        chk(rx, 16'hzzzz);
        rsp(16'h2800, 1'b0, 8'h2b);
    endtask
    task t_enable;
        ev(9'h008);
        en = 1'b1;
        w;
        chk(16'({o1, o2}), 16'h0003);
        rsp(16'h3338, 1'b0, 8'hff);
        ev(9'h008);
        dis = 1'b1;
        w;
        chk(16'({o1, o2}), 16'h0000);
        dis = 1'b0;
        w;
        rsp(16'h0900, 1'b0, 8'hff);
        lock = 1'b1;
        w;
        rsp(16'h0900, 1'b0, 8'h7f);
        lock = 1'b0;
        en = 1'b0;
        rsp(16'h3328, 1'b0, 8'h7f);
        en = 1'b1;
        w;
        chk(16'({o1, o2}), 16'h0001);
        en = 1'b0;
        rsp(16'h3338, 1'b0, 8'h7f);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #2ms;
        n_fail++;
        finish_test;
    end
    initial
    begin
        {rst, en, dis, lock, uv, flt} = {1'b1, 13'h0};
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        t_reset;
        t_setup;
        t_faults;
        t_errors;
        t_enable;
        finish_test;
    end
endmodule

bind bds_spi_core bds_spi_core_checker u_chk (.sys_clk_in, .rst_in, .spi_sclk_in, .select_n_in, .spi_so_out,
    .spi_so_oe_out, .enable_pin_in, .lockout_in, .out1_enable_out, .out2_enable_out, .limit_level_out,
    .pump_power_reduced_out, .fault_pin_role_out, .disable_or_fault_pin_oe_out);

// ===== bds_sync.sv
`timescale 1ns/1ps
module bds_sync #(
    parameter int           WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import bds_pkg::*;

    logic [WIDTH-1:0] meta_r;

    // the first stage feeds only the second
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            meta_r   <= INIT;
            sync_out <= INIT;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
